// >>> hdl/scchk_addr_dec.v
`timescale 1ns/1ns
`default_nettype none
`include "scchk_defines.vh"
module scchk_addr_dec (
   // address in
   input wire [`SCCHK_ADDR_W-1:0] addr,
   // one-hot select out
   output reg [`SCCHK_NUM_REGS-1:0] sel,
   output reg hit
);
   always @* begin
      sel = 6'h00;
      case (addr)
         `SCCHK_OFS_D5: sel = 6'h01;
         `SCCHK_OFS_D6: sel = 6'h02;
         `SCCHK_OFS_D7: sel = 6'h04;
         `SCCHK_OFS_D8: sel = 6'h08;
         `SCCHK_OFS_D9: sel = 6'h10;
         `SCCHK_OFS_DA: sel = 6'h20;
         default: sel = 6'h00;
      endcase
      hit = |sel;
   end
endmodule // scchk_addr_dec
`default_nettype wire

// >>> hdl/scchk_bank.v
`timescale 1ns/1ns
`default_nettype none
`include "scchk_defines.vh"
module scchk_bank (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // register port
   input wire [`SCCHK_ADDR_W-1:0] regAddr,
   input wire [`SCCHK_DATA_W-1:0] regWrData,
   input wire regWrStb,
   input wire regRdStb,
   output reg [`SCCHK_DATA_W-1:0] regRdData_q,
   // snapshot of all six words for the section crc
   output reg [`SCCHK_NUM_REGS*`SCCHK_DATA_W-1:0] crcImage_q
);

   // reset words as stored; the reserved span is never held
   localparam [`SCCHK_DATA_W-1:0] RST_D5 = `SCCHK_RST_D5 & `SCCHK_WMASK;
   localparam [`SCCHK_DATA_W-1:0] RST_D6 = `SCCHK_RST_D6 & `SCCHK_WMASK;
   localparam [`SCCHK_DATA_W-1:0] RST_D7 = `SCCHK_RST_D7 & `SCCHK_WMASK;
   localparam [`SCCHK_DATA_W-1:0] RST_D8 = `SCCHK_RST_D8 & `SCCHK_WMASK;
   localparam [`SCCHK_DATA_W-1:0] RST_D9 = `SCCHK_RST_D9 & `SCCHK_WMASK;
   localparam [`SCCHK_DATA_W-1:0] RST_DA = `SCCHK_RST_DA & `SCCHK_WMASK;

   // address decode and qualified strobes
   wire [`SCCHK_NUM_REGS-1:0] sel;
   wire hit;
   wire wrGo;
   wire rdGo;

   // write data with the reserved span cleared
   wire [2:0] wrUpper;
   wire [4:0] wrLower;
   wire [`SCCHK_DATA_W-1:0] wrClean;

   // read data before its register
   reg [`SCCHK_DATA_W-1:0] rdMux;

   // word at D5h
   reg wrEnD5;
   wire [`SCCHK_DATA_W-1:0] w0;
   wire [2:0] upperD5;
   wire [4:0] lowerD5;
   wire [`SCCHK_DATA_W-1:0] viewD5;
   reg [`SCCHK_DATA_W-1:0] rdTermD5;

   // word at D6h
   reg wrEnD6;
   wire [`SCCHK_DATA_W-1:0] w1;
   wire [2:0] upperD6;
   wire [4:0] lowerD6;
   wire [`SCCHK_DATA_W-1:0] viewD6;
   reg [`SCCHK_DATA_W-1:0] rdTermD6;

   // word at D7h
   reg wrEnD7;
   wire [`SCCHK_DATA_W-1:0] w2;
   wire [2:0] upperD7;
   wire [4:0] lowerD7;
   wire [`SCCHK_DATA_W-1:0] viewD7;
   reg [`SCCHK_DATA_W-1:0] rdTermD7;

   // word at D8h
   reg wrEnD8;
   wire [`SCCHK_DATA_W-1:0] w3;
   wire [2:0] upperD8;
   wire [4:0] lowerD8;
   wire [`SCCHK_DATA_W-1:0] viewD8;
   reg [`SCCHK_DATA_W-1:0] rdTermD8;

   // word at D9h
   reg wrEnD9;
   wire [`SCCHK_DATA_W-1:0] w4;
   wire [2:0] upperD9;
   wire [4:0] lowerD9;
   wire [`SCCHK_DATA_W-1:0] viewD9;
   reg [`SCCHK_DATA_W-1:0] rdTermD9;

   // word at DAh
   reg wrEnDA;
   wire [`SCCHK_DATA_W-1:0] w5;
   wire [2:0] upperDA;
   wire [4:0] lowerDA;
   wire [`SCCHK_DATA_W-1:0] viewDA;
   reg [`SCCHK_DATA_W-1:0] rdTermDA;

   // field access shared by the write, read and image paths
   function [2:0] upperField;
      input [`SCCHK_DATA_W-1:0] word;
      begin
         upperField = word[`SCCHK_UPPER_HI:`SCCHK_UPPER_LO];
      end
   endfunction

   function [4:0] lowerField;
      input [`SCCHK_DATA_W-1:0] word;
      begin
         lowerField = word[`SCCHK_LOWER_HI:`SCCHK_LOWER_LO];
      end
   endfunction

   // reserved span is rebuilt as zeros, so no stored bit can leak into it
   function [`SCCHK_DATA_W-1:0] packWord;
      input [2:0] upper;
      input [4:0] lower;
      begin
         packWord = {upper, 8'h00, lower}; // [R4]
      end
   endfunction

   scchk_addr_dec uDec (
      .addr(regAddr),
      .sel(sel),
      .hit(hit)
   );

   // unmapped addresses take no write and read back as zero
   assign wrGo = regWrStb & hit;
   assign rdGo = regRdStb & hit;

   assign wrUpper = upperField(regWrData);
   assign wrLower = lowerField(regWrData);
   assign wrClean = packWord(wrUpper, wrLower); // [R11]

   // check bits steer nothing else in the block [R3]
   // word at D5h
   always @* begin
      if (wrGo && sel[0]) begin
         wrEnD5 = 1'b1;
      end else begin
         wrEnD5 = 1'b0;
      end
   end
   scchk_word #(
      .RESET_VAL(RST_D5)
   ) uW0 ( // [R5]
      .clk(clk),
      .rst_n(rst_n),
      .wrEn(wrEnD5),
      .wrData(wrClean),
      .value_q(w0)
   );

   assign upperD5 = upperField(w0);
   assign lowerD5 = lowerField(w0);
   assign viewD5 = packWord(upperD5, lowerD5);
   always @* begin
      if (sel[0]) begin
         rdTermD5 = viewD5;
      end else begin
         rdTermD5 = 16'h0000;
      end
   end

   // word at D6h
   always @* begin
      if (wrGo && sel[1]) begin
         wrEnD6 = 1'b1;
      end else begin
         wrEnD6 = 1'b0;
      end
   end
   scchk_word #(
      .RESET_VAL(RST_D6)
   ) uW1 ( // [R6]
      .clk(clk),
      .rst_n(rst_n),
      .wrEn(wrEnD6),
      .wrData(wrClean),
      .value_q(w1)
   );

   assign upperD6 = upperField(w1);
   assign lowerD6 = lowerField(w1);
   assign viewD6 = packWord(upperD6, lowerD6);
   always @* begin
      if (sel[1]) begin
         rdTermD6 = viewD6;
      end else begin
         rdTermD6 = 16'h0000;
      end
   end

   // word at D7h
   always @* begin
      if (wrGo && sel[2]) begin
         wrEnD7 = 1'b1;
      end else begin
         wrEnD7 = 1'b0;
      end
   end
   scchk_word #(
      .RESET_VAL(RST_D7)
   ) uW2 ( // [R7]
      .clk(clk),
      .rst_n(rst_n),
      .wrEn(wrEnD7),
      .wrData(wrClean),
      .value_q(w2)
   );

   assign upperD7 = upperField(w2);
   assign lowerD7 = lowerField(w2);
   assign viewD7 = packWord(upperD7, lowerD7);
   always @* begin
      if (sel[2]) begin
         rdTermD7 = viewD7;
      end else begin
         rdTermD7 = 16'h0000;
      end
   end

   // word at D8h
   always @* begin
      if (wrGo && sel[3]) begin
         wrEnD8 = 1'b1;
      end else begin
         wrEnD8 = 1'b0;
      end
   end
   scchk_word #(
      .RESET_VAL(RST_D8)
   ) uW3 ( // [R8]
      .clk(clk),
      .rst_n(rst_n),
      .wrEn(wrEnD8),
      .wrData(wrClean),
      .value_q(w3)
   );

   assign upperD8 = upperField(w3);
   assign lowerD8 = lowerField(w3);
   assign viewD8 = packWord(upperD8, lowerD8);
   always @* begin
      if (sel[3]) begin
         rdTermD8 = viewD8;
      end else begin
         rdTermD8 = 16'h0000;
      end
   end

   // word at D9h
   always @* begin
      if (wrGo && sel[4]) begin
         wrEnD9 = 1'b1;
      end else begin
         wrEnD9 = 1'b0;
      end
   end
   scchk_word #(
      .RESET_VAL(RST_D9)
   ) uW4 ( // [R9]
      .clk(clk),
      .rst_n(rst_n),
      .wrEn(wrEnD9),
      .wrData(wrClean),
      .value_q(w4)
   );

   assign upperD9 = upperField(w4);
   assign lowerD9 = lowerField(w4);
   assign viewD9 = packWord(upperD9, lowerD9);
   always @* begin
      if (sel[4]) begin
         rdTermD9 = viewD9;
      end else begin
         rdTermD9 = 16'h0000;
      end
   end

   // word at DAh
   always @* begin
      if (wrGo && sel[5]) begin
         wrEnDA = 1'b1;
      end else begin
         wrEnDA = 1'b0;
      end
   end
   scchk_word #(
      .RESET_VAL(RST_DA)
   ) uW5 ( // [R10]
      .clk(clk),
      .rst_n(rst_n),
      .wrEn(wrEnDA),
      .wrData(wrClean),
      .value_q(w5)
   );

   assign upperDA = upperField(w5);
   assign lowerDA = lowerField(w5);
   assign viewDA = packWord(upperDA, lowerDA);
   always @* begin
      if (sel[5]) begin
         rdTermDA = viewDA;
      end else begin
         rdTermDA = 16'h0000;
      end
   end

   // one select is high at most, so the terms simply merge
   always @* begin
      rdMux = rdTermD5
         | rdTermD6
         | rdTermD7
         | rdTermD8
         | rdTermD9
         | rdTermDA;
   end

   // read data stands one cycle only; unmapped reads return zero
   // with both strobes high the read returns the word as it was before the write
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData_q <= 16'h0000;
      end else if (rdGo) begin
         regRdData_q <= rdMux; // [R1] [R4]
      end else begin
         regRdData_q <= 16'h0000;
      end
   end

   // registered copy, one cycle behind the words, D5h in the low word
   // the crc thus covers the same zeros in the reserved span that software reads
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crcImage_q[15:0] <= RST_D5;
         crcImage_q[31:16] <= RST_D6;
         crcImage_q[47:32] <= RST_D7;
         crcImage_q[63:48] <= RST_D8;
         crcImage_q[79:64] <= RST_D9;
         crcImage_q[95:80] <= RST_DA;
      end else begin
         crcImage_q[15:0] <= viewD5; // [R2]
         crcImage_q[31:16] <= viewD6; // [R2]
         crcImage_q[47:32] <= viewD7; // [R2]
         crcImage_q[63:48] <= viewD8; // [R2]
         crcImage_q[79:64] <= viewD9; // [R2]
         crcImage_q[95:80] <= viewDA; // [R2]
      end
   end

endmodule // scchk_bank
`default_nettype wire

// >>> hdl/scchk_defines.vh
// Overview of operation
// (R1) Bits 15:13 and 4:0 of each bank word are read/write storage.
// (R2) Writable check fields are exposed on the snapshot port for section CRC.
// (R3) Check fields steer nothing; they are pure storage.
// (R4) Bits 12:5 read as zero always, whatever is written.
// (R5) Word at D5h resets to 0005h.
// (R6) Word at D6h resets to 0006h.
// (R7) Word at D7h resets to 0007h.
// (R8) Word at D8h resets to 0008h.
// (R9) Word at D9h resets to 0009h.
// (R10) Word at DAh resets to 000Ah.
// (R11) A write updates only the two check fields; reserved bits stay zero.
`ifndef SCCHK_DEFINES_VH
`define SCCHK_DEFINES_VH
`define SCCHK_ADDR_W 8
`define SCCHK_DATA_W 16
`define SCCHK_NUM_REGS 6
`define SCCHK_OFS_D5 8'hd5
`define SCCHK_OFS_D6 8'hd6
`define SCCHK_OFS_D7 8'hd7
`define SCCHK_OFS_D8 8'hd8
`define SCCHK_OFS_D9 8'hd9
`define SCCHK_OFS_DA 8'hda
`define SCCHK_RST_D5 16'h0005
`define SCCHK_RST_D6 16'h0006
`define SCCHK_RST_D7 16'h0007
`define SCCHK_RST_D8 16'h0008
`define SCCHK_RST_D9 16'h0009
`define SCCHK_RST_DA 16'h000a
`define SCCHK_UPPER_HI 15
`define SCCHK_UPPER_LO 13
`define SCCHK_LOWER_HI 4
`define SCCHK_LOWER_LO 0
`define SCCHK_WMASK 16'he01f
`endif

// >>> hdl/scchk_word.v
`timescale 1ns/1ns
`default_nettype none
`include "scchk_defines.vh"
module scchk_word #(
   parameter [`SCCHK_DATA_W-1:0] RESET_VAL = 16'h0000
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // write side
   input wire wrEn,
   input wire [`SCCHK_DATA_W-1:0] wrData,
   // stored value
   output reg [`SCCHK_DATA_W-1:0] value_q
);
   // reserved bits are never stored, so they cannot drift from zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         value_q <= RESET_VAL & `SCCHK_WMASK;
      end else if (wrEn) begin
         value_q <= wrData & `SCCHK_WMASK; // [R1] [R4] [R11]
      end
   end
endmodule // scchk_word
`default_nettype wire

// >>> tb/scchk_bank_sva.sv
`timescale 1ns/1ns
`default_nettype none
module scchk_bank_sva (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [15:0] regRdData_q,
   input wire logic [95:0] crcImage_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_wrrd;
      regWrStb && regAddr inside {[8'hd5:8'hda]} ##1 regRdStb && $stable(regAddr);
   endsequence
   sequence s_quiet;
      !regWrStb [*2];
   endsequence
   property p_rw; s_wrrd |=> regRdData_q == ($past(regWrData, 2) & 16'he01f); endproperty
   a_rw: assert property (p_rw) else $error("bad readback");
   property p_rdimg; s_quiet ##0 regRdStb && regAddr == 8'hd5 |=> regRdData_q == crcImage_q[15:0]; endproperty
   a_rdimg: assert property (p_rdimg) else $error("image differs");
   property p_hold; s_quiet |=> $stable(crcImage_q); endproperty
   a_hold: assert property (p_hold) else $error("image moved");
   property p_rst; $rose(rst_n) |-> crcImage_q == 96'h000a_0009_0008_0007_0006_0005; endproperty
   a_rst: assert property (p_rst) else $error("bad reset");
   property p_res; regRdData_q[12:5] == 8'h00; endproperty
   a_res: assert property (p_res) else $error("reserved set");
   property p_img0; (crcImage_q & {6{16'h1fe0}}) == 96'h0; endproperty
   a_img0: assert property (p_img0) else $error("reserved kept");
   property p_unm; regRdStb && !(regAddr inside {[8'hd5:8'hda]}) |=> regRdData_q == 16'h0000; endproperty
   a_unm: assert property (p_unm) else $error("unmapped data");
   property p_idle; !regRdStb |=> regRdData_q == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("stale data");
endmodule // scchk_bank_sva
bind scchk_bank scchk_bank_sva u_sva (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
   .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData_q(regRdData_q), .crcImage_q(crcImage_q));
`default_nettype wire

// >>> tb/scchk_bank_tb.sv
`timescale 1ns/1ns
`default_nettype none
module scchk_bank_tb;
   logic clk = 0, rst_n = 0, regWrStb = 0, regRdStb = 0;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWrData = 16'h0000, rdVal;
   wire logic [15:0] rdData;
   wire logic [95:0] crcImage;
   int fail_count = 0, checks_done = 0;
   scchk_bank u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
      .regRdStb(regRdStb), .regRdData_q(rdData), .crcImage_q(crcImage));
   initial forever #2 clk = ~clk;
   task chk(input logic [95:0] seen, input logic [95:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // write (optional) then read in the next cycle, data taken in its only valid cycle
   task acc(input logic wr, input logic [7:0] a, input logic [15:0] w);
      @(posedge clk);
      regAddr <= a;
      regWrData <= w;
      if (wr) begin
         regWrStb <= 1;
         @(posedge clk);
         regWrStb <= 0;
      end
      regRdStb <= 1;
      @(posedge clk);
      regRdStb <= 0;
      #1 rdVal = rdData;
   endtask
   task t_reset;
      for (int i = 0; i < 6; i++) begin
         acc(0, 8'hd5 + i[7:0], 16'h0);
         chk(rdVal, 16'h0005 + i[15:0]);
      end
      chk(crcImage, 96'h000a_0009_0008_0007_0006_0005);
   endtask
   task t_write;
      for (int i = 0; i < 12; i++) begin
         acc(1, 8'hd5 + i[7:0] % 8'h06, i < 6 ? 16'hffff : 16'h2aaa);
         chk(rdVal, i < 6 ? 16'he01f : 16'h200a);
      end
   endtask
   task t_unmapped;
      acc(1, 8'hd4, 16'hffff);
      chk(rdVal, 16'h0000);
      chk(crcImage, {6{16'h200a}});
      acc(0, 8'hd5, 16'h0);
      chk(rdVal, 16'h200a);
   endtask
   // reset in mid-run must override the written fields
   task t_midreset;
      @(posedge clk);
      rst_n <= 0;
      repeat (2) @(posedge clk);
      rst_n <= 1;
      t_reset;
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1;
      t_reset;
      t_write;
      t_unmapped;
      t_midreset;
      stop_test;
   end
endmodule // scchk_bank_tb
`default_nettype wire
